// ==== hdl/uhis_core.sv ====
`timescale 1ns/1ps
module uhis_core #(
    parameter bit HAS_MGMT_PIN = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // register access
    input wire uhis_pkg::uhis_access_s acc,
    output logic [31:0] rdata,
    // enable register and command-status contents from neighbours
    input wire logic [31:0] interrupt_event_enable,
    input wire logic ownership_request_bit,
    input wire logic resume_functional_state,
    // controller events, same clock
    input wire uhis_pkg::uhis_events_s events,
    input wire logic [15:0] frame_number_counter,
    // resume signalling from the port pins, asynchronous
    input wire logic resume_pin,
    // outputs
    output logic irq,
    output logic system_mgmt_irq_pin,
    output logic processing_halt,
    output logic done_write_allowed,
    output logic [1:0] overrun_tally
);
    import uhis_pkg::*;

    // ***************************************************************
    // state
    // ***************************************************************
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [1:0] tally_reg;
    logic frame_msb_reg;
    logic resume_reg;
    logic own_req_reg;
    logic resume_sync;
    uhis_state_e err_state_reg;
    uhis_state_e err_state_next;

    uhis_sync u_resume_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(resume_pin),
        .sync_out(resume_sync)
    );

    // ***************************************************************
    // event detection
    // ***************************************************************
    wire status_sel = (acc.addr == UHIS_STATUS_OFFSET);
    wire status_wr = acc.wr && status_sel;
    wire frame_toggle = frame_number_counter[UHIS_BIT_FRAME_MSB] != frame_msb_reg;
    // a resume entered by software is not a detected resume
    wire resume_rise = resume_sync && !resume_reg && !resume_functional_state;
    wire own_rise = ownership_request_bit && !own_req_reg;
    wire [31:0] set_vec;
    wire [31:0] clr_vec;

    assign set_vec[UHIS_BIT_OVERRUN] = events.overrun;
    assign set_vec[UHIS_BIT_DONE] = events.done_written;
    assign set_vec[UHIS_BIT_SOF] = events.frame_start;
    assign set_vec[UHIS_BIT_RESUME] = resume_rise;
    assign set_vec[UHIS_BIT_ERROR] = events.system_error;
    assign set_vec[UHIS_BIT_FRAME] = frame_toggle || events.frame_copy_done;
    assign set_vec[UHIS_BIT_ROOT] = events.root_change;
    assign set_vec[29:7] = '0;
    assign set_vec[UHIS_BIT_OWNER] = own_rise && HAS_MGMT_PIN;
    assign set_vec[UHIS_BIT_MASTER] = 1'b0;

    // write data only ever clears; reserved positions are masked
    assign clr_vec = status_wr ? (acc.wdata & UHIS_FLAG_MASK) : 32'h0000_0000;
    // set wins over a clear in the same cycle; hardware has no clear path
    assign status_next = ((status_reg & ~clr_vec) | set_vec) & UHIS_FLAG_MASK;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_reg <= UHIS_STATUS_RESET;
            frame_msb_reg <= 1'b0;
            resume_reg <= 1'b0;
            own_req_reg <= 1'b0;
        end else if (clk_en) begin
            status_reg <= status_next;
            frame_msb_reg <= frame_number_counter[UHIS_BIT_FRAME_MSB];
            resume_reg <= resume_sync;
            own_req_reg <= ownership_request_bit;
        end
    end

    // ***************************************************************
    // overrun tally
    // ***************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tally_reg <= UHIS_TALLY_RESET;
        end else if (clk_en && events.overrun) begin
            tally_reg <= tally_reg + 2'h1;
        end
    end
    assign overrun_tally = tally_reg;

    // ***************************************************************
    // error halt
    // ***************************************************************
    always_comb begin
        err_state_next = err_state_reg;
        case (err_state_reg)
            UHIS_RUN: begin
                if (events.system_error) begin
                    err_state_next = UHIS_HALT;
                end
            end
            UHIS_HALT: begin
                // software resets the controller before clearing
                // a fresh error while the flag is being cleared keeps the halt
                if (!status_reg[UHIS_BIT_ERROR] && !events.system_error) begin
                    err_state_next = UHIS_WAIT_CLEAR;
                end
            end
            UHIS_WAIT_CLEAR: begin
                if (events.system_error) begin
                    err_state_next = UHIS_HALT;
                end else begin
                    err_state_next = UHIS_RUN;
                end
            end
            default: begin
                err_state_next = UHIS_HALT;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_state_reg <= UHIS_RUN;
        end else if (clk_en) begin
            err_state_reg <= err_state_next;
        end
    end
    assign processing_halt = (err_state_reg == UHIS_HALT) || events.system_error;

    // ***************************************************************
    // done pointer write permission
    // ***************************************************************
    assign done_write_allowed = !status_reg[UHIS_BIT_DONE];

    // ***************************************************************
    // interrupt outputs
    // ***************************************************************
    wire [31:0] gated = status_reg & interrupt_event_enable & UHIS_FLAG_MASK;
    wire master_on = interrupt_event_enable[UHIS_BIT_MASTER];
    wire irq_next = master_on && (|gated);
    wire smi_next = gated[UHIS_BIT_OWNER];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            system_mgmt_irq_pin <= 1'b0;
        end else if (clk_en) begin
            irq <= irq_next;
            system_mgmt_irq_pin <= smi_next;
        end
    end

    // ***************************************************************
    // read data
    // ***************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata <= (acc.rd && status_sel) ? status_reg : 32'h0000_0000;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_flag_sets_on_event: assert property (clk_en && events.frame_start |=> status_reg[UHIS_BIT_SOF]) else $error("frame start flag not set");
    a_write_clears_flag: assert property (clk_en && status_wr && acc.wdata[UHIS_BIT_SOF] && !events.frame_start |=> !status_reg[UHIS_BIT_SOF]) else $error("write one did not clear");
    a_flag_never_set_by_sw: assert property (clk_en && !status_reg[UHIS_BIT_ROOT] && !events.root_change |=> !status_reg[UHIS_BIT_ROOT]) else $error("flag set without event");
    a_flag_held_high: assert property (clk_en && status_reg[UHIS_BIT_DONE] && !(status_wr && acc.wdata[UHIS_BIT_DONE]) |=> status_reg[UHIS_BIT_DONE]) else $error("flag dropped by hardware");
    a_reserved_reads_zero: assert property ((status_reg & ~UHIS_FLAG_MASK) == 32'h0000_0000) else $error("reserved bit set");
    a_irq_follows_gate: assert property (clk_en |=> irq == $past(irq_next)) else $error("irq mismatch");
    a_irq_needs_master: assert property (clk_en && !master_on |=> !irq) else $error("irq without master gate");
    a_tally_counts: assert property (clk_en && events.overrun |=> tally_reg == $past(tally_reg) + 2'h1) else $error("tally did not count");
    a_error_halts: assert property (clk_en && events.system_error |=> processing_halt) else $error("no halt after error");
    a_done_blocks_write: assert property (status_reg[UHIS_BIT_DONE] |-> !done_write_allowed) else $error("rewrite allowed");
    a_smi_on_owner: assert property (clk_en && smi_next |=> system_mgmt_irq_pin) else $error("smi missing");

    c_irq_raised: cover property (clk_en && !irq ##1 irq);
    c_overrun_wrap: cover property (clk_en && events.overrun && tally_reg == 2'h3);
    c_clear_and_set: cover property (clk_en && status_wr && acc.wdata[UHIS_BIT_SOF] && events.frame_start);
    c_halt_release: cover property (err_state_reg == UHIS_WAIT_CLEAR);

endmodule

// ==== hdl/uhis_pkg.sv ====
package uhis_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] UHIS_STATUS_OFFSET = 8'h0C;
    localparam logic [31:0] UHIS_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] UHIS_ENABLE_RESET = 32'h0000_0000;
    localparam logic [1:0] UHIS_TALLY_RESET = 2'h0;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int UHIS_BIT_OVERRUN = 0;
    localparam int UHIS_BIT_DONE = 1;
    localparam int UHIS_BIT_SOF = 2;
    localparam int UHIS_BIT_RESUME = 3;
    localparam int UHIS_BIT_ERROR = 4;
    localparam int UHIS_BIT_FRAME = 5;
    localparam int UHIS_BIT_ROOT = 6;
    localparam int UHIS_BIT_OWNER = 30;
    localparam int UHIS_BIT_MASTER = 31;
    localparam int UHIS_BIT_OWN_REQ = 3;
    localparam int UHIS_BIT_FRAME_MSB = 15;
    localparam int UHIS_NUM_LOW = 7;
    localparam logic [31:0] UHIS_FLAG_MASK = 32'h4000_007F;

    // ***************************************************************
    // event strobes from the controller
    // ***************************************************************
    typedef struct packed {
        logic root_change;
        logic frame_copy_done;
        logic system_error;
        logic resume_signal;
        logic frame_start;
        logic done_written;
        logic overrun;
    } uhis_events_s;

    // ***************************************************************
    // register access port
    // ***************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } uhis_access_s;

    typedef enum logic [2:0] {
        UHIS_RUN = 3'b001,
        UHIS_HALT = 3'b010,
        UHIS_WAIT_CLEAR = 3'b100
    } uhis_state_e;

endpackage

// ==== hdl/uhis_sync.sv ====
`timescale 1ns/1ps
module uhis_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    import uhis_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // a change counts once the second and third stages agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                sync_out <= s3_reg;
            end
        end
    end

endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import uhis_pkg::*;

    logic ref_clk, rst, clk_en, own_req, res_state, res_pin;
    logic irq, smi, halt, dwa;
    logic [1:0] tally, exp_tally;
    logic [31:0] rdata, ena, exp;
    logic [15:0] fnc;
    uhis_access_s acc;
    uhis_events_s ev;
    int n_fail, checks_done, cycles;
    int ids [6] = '{0, 1, 2, 5, 6, 4};

    uhis_core #(.HAS_MGMT_PIN(1'b1)) uhis_core_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .acc(acc), .rdata(rdata), .interrupt_event_enable(ena),
        .ownership_request_bit(own_req), .resume_functional_state(res_state), .events(ev),
        .frame_number_counter(fnc), .resume_pin(res_pin), .irq(irq),
        .system_mgmt_irq_pin(smi), .processing_halt(halt), .done_write_allowed(dwa),
        .overrun_tally(tally));

    uhis_host_model uhis_host_model_i (.ref_clk(ref_clk), .rdata(rdata), .acc(acc));

    // ***************************************************************
    // clock, timeout and verdict
    // ***************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ***************************************************************
    // shared helpers
    // ***************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, want);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] d;
        uhis_host_model_i.rd_reg(a, d);
        chk(d, want);
    endtask

    task automatic pulse(input int i);
        @(negedge ref_clk);
        ev = uhis_events_s'(7'h01 << i);
        @(negedge ref_clk);
        ev = '0;
        @(negedge ref_clk);
        if (i == UHIS_BIT_OVERRUN) exp_tally = exp_tally + 2'h1;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        rst = 1'b1;
        {own_req, res_state, res_pin} = 3'b000;
        clk_en = 1'b1;
        ena = 32'h0000_0000;
        fnc = 16'h0000;
        ev = '0;
        exp = 32'h0000_0000;
        exp_tally = 2'h0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk({26'h0, dwa, irq, smi, halt, tally}, 32'h0000_0020);
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0000);
        // every controller event except resume_signal, the error last so nothing is halted before it
        foreach (ids[k]) begin
            pulse(ids[k]);
            exp = exp | (32'h0000_0001 << ids[k]);
            rd_chk(UHIS_STATUS_OFFSET, exp);
        end
        chk({30'h0, halt, dwa}, 32'h0000_0002);
        chk({30'h0, tally}, {30'h0, exp_tally});
        // unmapped place: reads zero, writes leave the flags alone
        rd_chk(8'h10, 32'h0000_0000);
        uhis_host_model_i.wr_reg(8'h10, 32'h4000_007F);
        rd_chk(UHIS_STATUS_OFFSET, exp);
        ena = 32'h0000_007F;
        settle(2);
        chk({31'h0, irq}, 32'h0000_0000);
        ena = 32'h8000_007F;
        settle(2);
        chk({31'h0, irq}, 32'h0000_0001);
        // done pointer already saved by the read above, controller reset done, then cleared
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h0000_0012);
        settle(1);
        rd_chk(UHIS_STATUS_OFFSET, exp & 32'hFFFF_FFED);
        chk({30'h0, halt, dwa}, 32'h0000_0001);
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h4000_007F);
        settle(1);
        chk({31'h0, irq}, 32'h0000_0000);
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h4000_007F);
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0000);
        // ownership change reaches the management pin with master off
        ena = 32'h4000_0000;
        @(negedge ref_clk);
        own_req = 1'b1;
        settle(3);
        chk({30'h0, smi, irq}, 32'h0000_0002);
        rd_chk(UHIS_STATUS_OFFSET, 32'h4000_0000);
        own_req = 1'b0;
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h4000_0000);
        // frame counter top bit toggles
        fnc = 16'h8000;
        settle(2);
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0020);
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h0000_0020);
        // resume driven by software first, then by a device
        res_state = 1'b1;
        res_pin = 1'b1;
        settle(8);
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0000);
        res_pin = 1'b0;
        settle(8);
        res_state = 1'b0;
        res_pin = 1'b1;
        settle(8);
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0008);
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h0000_0008);
        // overruns keep counting with the flag already set, then wrap
        repeat (4) pulse(UHIS_BIT_OVERRUN);
        chk({30'h0, tally}, {30'h0, exp_tally});
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0001);
        // a frozen block takes neither events nor clearing writes
        clk_en = 1'b0;
        pulse(UHIS_BIT_DONE);
        uhis_host_model_i.wr_reg(UHIS_STATUS_OFFSET, 32'h0000_0001);
        clk_en = 1'b1;
        rd_chk(UHIS_STATUS_OFFSET, 32'h0000_0001);
        chk({31'h0, dwa}, 32'h0000_0001);
        summarize();
    end
endmodule

// ==== testbench/uhis_host_model.sv ====
`timescale 1ns/1ps
module uhis_host_model (
    // clock
    input wire logic ref_clk,
    // register access
    input wire logic [31:0] rdata,
    output uhis_pkg::uhis_access_s acc
);
    import uhis_pkg::*;

    initial acc = '0;

    // ***************************************************************
    // driver accesses, launched and released on the falling edge
    // ***************************************************************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        acc.wr = 1'b1;
        acc.addr = a;
        acc.wdata = d & UHIS_FLAG_MASK;
        @(negedge ref_clk);
        acc = '0;
    endtask

    // read data stands from the taking edge on and is picked up at the next falling edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(negedge ref_clk);
        acc.rd = 1'b1;
        acc.addr = a;
        @(negedge ref_clk);
        d = rdata;
        acc = '0;
    endtask
endmodule
